// *** logic/tac_defines.vh ***
// Purpose: Constants of the thermal alert configuration registers
// Assumes: Register pointer of three bits, 16-bit register words
// Notes:   Definitions only
`ifndef TAC_DEFINES_VH
`define TAC_DEFINES_VH

// ----------------------------------------------------------------------
// Register pointers
// ----------------------------------------------------------------------
`define TAC_ADDR_FEATURE   3'h0
`define TAC_ADDR_SETUP     3'h1
`define TAC_ADDR_UPPER     3'h2

// ----------------------------------------------------------------------
// Feature report fields and fixed value
// ----------------------------------------------------------------------
`define TAC_FEAT_VALUE     16'h007f
`define TAC_FEAT_MASK      16'h00ff
`define TAC_FEAT_HALT_BHV  7
`define TAC_FEAT_TIMEOUT   6
`define TAC_FEAT_RES_HI    4
`define TAC_FEAT_RES_LO    3
`define TAC_FEAT_NEG       2
`define TAC_FEAT_GRADE     1
`define TAC_FEAT_ALARMS    0

// ----------------------------------------------------------------------
// Alert setup fields
// ----------------------------------------------------------------------
`define TAC_SET_MARGIN_HI  10
`define TAC_SET_MARGIN_LO  9
`define TAC_SET_HALT       8
`define TAC_SET_CRITLOCK   7
`define TAC_SET_ALARMLOCK  6
`define TAC_SET_CLEAR      5
`define TAC_SET_STATE      4
`define TAC_SET_ENABLE     3
`define TAC_SET_CRITONLY   2
`define TAC_SET_LEVEL      1
`define TAC_SET_MODE       0

// ----------------------------------------------------------------------
// Limit format and hysteresis steps of 1/16 degree
// ----------------------------------------------------------------------
`define TAC_LIMIT_MASK     16'h1ffc
`define TAC_THRESHOLD_MARGIN_SEL_NONE      8'h00
`define TAC_THRESHOLD_MARGIN_SEL_1P5       8'h18
`define TAC_THRESHOLD_MARGIN_SEL_3         8'h30
`define TAC_THRESHOLD_MARGIN_SEL_6         8'h60

// Comparison kinds
`define TAC_KIND_ABOVE     0
`define TAC_KIND_BELOW     1
`define TAC_KIND_CRIT      2

`endif

// *** logic/tac_limit_cmp.v ***
// Purpose: One limit comparison with hysteresis on the recorded temperature
// Assumes: Temperature and limit in two's complement, 1/16 degree per step
// Notes:   Flag holds while the sensor is halted
`timescale 1ns/10ps
`default_nettype none
`include "tac_defines.vh"

module tac_limit_cmp #(
   parameter KIND = 0
) (
   // Clock and reset
   input  wire        clk,
   input  wire        rst,
   // Comparison inputs
   input  wire [12:0] temp,
   input  wire [15:0] limit,
   input  wire [7:0]  threshold_margin_sel,
   input  wire        run,
   // Result
   output reg         flag
);

   wire signed [13:0] t  = {temp[12], temp};
   wire signed [13:0] l  = {limit[12], limit[12:0]};
   wire signed [13:0] lh = l - $signed({6'h00, threshold_margin_sel});
   reg                setC;
   reg                clrC;

   // Set and end conditions; the end sits one margin below the limit, except for TAC_KIND_BELOW where the set does
   always @* begin
      case (KIND)
         `TAC_KIND_ABOVE: begin
            setC = (t > l);
            clrC = (t <= lh);
         end
         `TAC_KIND_BELOW: begin
            setC = (t < lh);
            clrC = (t >= l);
         end
         default: begin
            setC = (t >= l);
            clrC = (t < lh);
         end
      endcase
   end

   // Evaluated every cycle while run is high, so limit writes act at once
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         flag <= 1'b0;
      end else if (run) begin
         if (setC) begin
            flag <= 1'b1;
         end else if (clrC) begin
            flag <= 1'b0;
         end
      end
   end

endmodule // tac_limit_cmp
`default_nettype wire

// *** logic/tac_alert_latch.v ***
// Purpose: Recorded alert of interrupt mode with deferred clearing
// Assumes: Event and clear inputs are one-cycle pulses
// Notes:   A clear seen while critical waits until the critical flag drops
`timescale 1ns/10ps
`default_nettype none

module tac_alert_latch (
   // Clock and reset
   input  wire clk,
   input  wire rst,
   // Controls
   input  wire run,
   input  wire evt,
   input  wire critHot,
   input  wire clrReq,
   input  wire haltDrop,
   // Result
   output reg  state
);

   reg pending;

   // Set wins over clear; critical holds the alert up
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state   <= 1'b0;
         pending <= 1'b0;
      end else begin
         if (run && (evt || critHot)) begin
            state <= 1'b1;
         end else if (haltDrop) begin
            state <= 1'b0;
         end else if ((clrReq || pending) && !critHot) begin
            state <= 1'b0;
         end
         // Clear acknowledged now, executed when critical ends
         if (clrReq && critHot) begin
            pending <= 1'b1;
         end else if (!critHot) begin
            pending <= 1'b0;
         end
      end
   end

endmodule // tac_alert_latch
`default_nettype wire

// *** logic/tac_alert_regs.v ***
// Purpose: Feature, alert setup and upper alarm registers with alert pin logic
// Assumes: Serial engine hands over pointer, data and one-cycle strobes
// Notes:   Lower and critical limits live outside and arrive as inputs
//
// How it works
// - Reserved high bits of feature and setup registers ignore writes, read zero.
// - Feature bit 7 says whether halting freezes or clears the alert state.
// - While halted, alert state may clear by request but never sets.
// - Feature bit 6 reports bus timeout window, 10-60 ms or 25-35 ms.
// - Feature bits 4:3 give resolution, half to sixteenth degree.
// - Feature bits 2:0 are fixed negative-range, precision and alarm flags.
// - Setup bits 10:9 select hysteresis: none, 1.5, 3 or 6 degrees.
// - Halt bit stops conversions and freezes the recorded temperature.
// - Halt clears at reset, cannot be set while locked, clears anytime.
// - Critical lock bit rejects critical limit writes; only reset clears it.
// - Alarm lock bit rejects upper and lower limit writes; only reset clears it.
// - Hysteresis, enable, level and mode bits frozen while either lock set.
// - Critical-only bit cannot be set while alarm lock is set.
// - Clear bit clears a recorded alert in interrupt mode; reads zero.
// - Clear seen while at or above the critical limit waits until the critical flag drops.
// - State copy bit shows alert pin assertion, polarity free, gated by enable.
// - Disabled pin sits inactive; enabled pin follows the alert logic.
// - Critical-only bit restricts alert sources to critical crossings.
// - Level bit sets pin polarity; pin is open-drain either way.
// - Mode bit selects comparator or interrupt behaviour.
// - Upper limit holds sign in bit 12, bits 15:13 and 1:0 read zero.
// - Interrupt mode asserts on each window crossing until cleared.
// - Comparator asserts outside window; critical-only asserts at or above critical.
// - While not halted, alert re-evaluates at once when a limit changes.
`timescale 1ns/10ps
`default_nettype none
`include "tac_defines.vh"

module tac_alert_regs (
   // Clock and reset
   input  wire        clk,
   input  wire        rst,
   // Register access from the serial engine
   input  wire [2:0]  regAddr,
   input  wire [15:0] regWrData,
   input  wire        regWrite,
   output reg  [15:0] regRdData,
   // Converter
   input  wire [12:0] sampleTemp,
   input  wire        sampleValid,
   output reg         convRun,
   output reg  [12:0] recordedTemp,
   // Limits held outside this block
   input  wire [15:0] lowerLimit,
   input  wire [15:0] criticalLimit,
   output reg         alarmLimitFreeze,
   output reg         critLimitFreeze,
   // Open-drain alert pin
   output reg         alertPinOut,
   output reg         alertPinOe
);

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------

   // Hysteresis select to 1/16 degree steps
   function [7:0] marginSteps;
      input [1:0] sel;
      begin
         case (sel)
            2'b00:   marginSteps = `TAC_THRESHOLD_MARGIN_SEL_NONE;
            2'b01:   marginSteps = `TAC_THRESHOLD_MARGIN_SEL_1P5;
            2'b10:   marginSteps = `TAC_THRESHOLD_MARGIN_SEL_3;
            default: marginSteps = `TAC_THRESHOLD_MARGIN_SEL_6;
         endcase
      end
   endfunction

   // Pointer decode, used for writes and reads
   function isAddr;
      input [2:0] a;
      input [2:0] b;
      begin
         isAddr = (a == b);
      end
   endfunction

   // ----------------------------------------------------------------------
   // Setup register state
   // ----------------------------------------------------------------------
   reg  [1:0]  thresholdMarginSel;
   reg         sensorHalt;
   reg         alertEnable;
   reg         critAloneSel;
   reg         alertLevelSel;
   reg         alertMode;
   reg  [15:0] upperAlarmThreshold;
   reg         haltPrev;
   reg         compState;
   reg  [2:0]  flagPrev;

   wire        setupWr = regWrite && isAddr(regAddr, `TAC_ADDR_SETUP);
   wire        upperWr = regWrite && isAddr(regAddr, `TAC_ADDR_UPPER);
   wire        lockAny = critLimitFreeze || alarmLimitFreeze;
   wire [15:0] featureReport = `TAC_FEAT_VALUE & `TAC_FEAT_MASK;
   wire        haltClears = featureReport[`TAC_FEAT_HALT_BHV];

   // Setup writes with lock interlocks; old lock values gate this write
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         thresholdMarginSel <= 2'b00;
         sensorHalt         <= 1'b0;
         critLimitFreeze    <= 1'b0;
         alarmLimitFreeze   <= 1'b0;
         alertEnable        <= 1'b0;
         critAloneSel       <= 1'b0;
         alertLevelSel      <= 1'b0;
         alertMode          <= 1'b0;
      end else if (setupWr) begin
         if (regWrData[`TAC_SET_CRITLOCK]) begin
            critLimitFreeze <= 1'b1;
         end
         if (regWrData[`TAC_SET_ALARMLOCK]) begin
            alarmLimitFreeze <= 1'b1;
         end
         if (!regWrData[`TAC_SET_HALT]) begin
            sensorHalt <= 1'b0;
         end else if (!lockAny) begin
            sensorHalt <= 1'b1;
         end
         if (!lockAny) begin
            thresholdMarginSel <= regWrData[`TAC_SET_MARGIN_HI:`TAC_SET_MARGIN_LO];
            alertEnable        <= regWrData[`TAC_SET_ENABLE];
            alertLevelSel      <= regWrData[`TAC_SET_LEVEL];
            alertMode          <= regWrData[`TAC_SET_MODE];
         end
         if (!regWrData[`TAC_SET_CRITONLY] || !alarmLimitFreeze) begin
            critAloneSel <= regWrData[`TAC_SET_CRITONLY];
         end
      end
   end

   // Upper limit; unused low and high bits are forced to zero
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         upperAlarmThreshold <= 16'h0000;
      end else if (upperWr && !alarmLimitFreeze) begin
         upperAlarmThreshold <= regWrData & `TAC_LIMIT_MASK;
      end
   end

   // ----------------------------------------------------------------------
   // Converter hold
   // ----------------------------------------------------------------------

   // Samples are only recorded while running; halt freezes the reading
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         recordedTemp <= 13'h0000;
         convRun      <= 1'b0;
      end else begin
         convRun <= !sensorHalt;
         if (sampleValid && !sensorHalt) begin
            recordedTemp <= sampleTemp;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Limit comparisons: upper, lower, critical
   // ----------------------------------------------------------------------
   wire [2:0]  limitFlag;
   wire [47:0] limitBus = {criticalLimit, lowerLimit, upperAlarmThreshold};
   wire [7:0]  margin   = marginSteps(thresholdMarginSel);

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : gCmp
         tac_limit_cmp #(
            .KIND (gi)
         ) uCmp (
            .clk   (clk),
            .rst   (rst),
            .temp  (recordedTemp),
            .limit (limitBus[gi*16 +: 16]),
            .threshold_margin_sel  (margin),
            .run   (!sensorHalt),
            .flag  (limitFlag[gi])
         );
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Alert decision
   // ----------------------------------------------------------------------
   wire critHot    = limitFlag[2];
   wire windowOut  = critAloneSel ? critHot : (|limitFlag);
   wire flagChange = critAloneSel ? (critHot && !flagPrev[2])
                                  : (|(limitFlag[1:0] ^ flagPrev[1:0]))
                                    || (critHot && !flagPrev[2]);
   wire haltRise   = sensorHalt && !haltPrev;
   wire haltDrop   = haltRise && haltClears;
   wire clrReq     = setupWr && regWrData[`TAC_SET_CLEAR] && alertMode;
   wire latchState;

   // Edge history and the comparator-mode state
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         flagPrev  <= 3'b000;
         haltPrev  <= 1'b0;
         compState <= 1'b0;
      end else begin
         flagPrev <= limitFlag;
         haltPrev <= sensorHalt;
         if (haltDrop) begin
            compState <= 1'b0;
         end else if (!sensorHalt) begin
            compState <= windowOut;
         end
      end
   end

   tac_alert_latch uLatch (
      .clk      (clk),
      .rst      (rst),
      .run      (!sensorHalt),
      .evt      (flagChange),
      .critHot  (critHot),
      .clrReq   (clrReq),
      .haltDrop (haltDrop),
      .state    (latchState)
   );

   wire alertState = alertMode ? latchState : compState;
   wire asserted   = alertState && alertEnable;

   // Open-drain pin: active low pulls when asserted, active high pulls when idle
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         alertPinOut <= 1'b0;
         alertPinOe  <= 1'b0;
      end else begin
         alertPinOut <= 1'b0;
         alertPinOe  <= asserted ^ alertLevelSel;
      end
   end

   // ----------------------------------------------------------------------
   // Read back
   // ----------------------------------------------------------------------
   wire [15:0] setupView = {5'h00, thresholdMarginSel, sensorHalt, critLimitFreeze,
                            alarmLimitFreeze, 1'b0, asserted, alertEnable,
                            critAloneSel, alertLevelSel, alertMode};

   // Data for the current pointer, registered; other pointers read zero here
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         regRdData <= 16'h0000;
      end else if (isAddr(regAddr, `TAC_ADDR_FEATURE)) begin
         regRdData <= featureReport;
      end else if (isAddr(regAddr, `TAC_ADDR_SETUP)) begin
         regRdData <= setupView;
      end else if (isAddr(regAddr, `TAC_ADDR_UPPER)) begin
         regRdData <= upperAlarmThreshold;
      end else begin
         regRdData <= 16'h0000;
      end
   end

endmodule // tac_alert_regs
`default_nettype wire

// *** sim/tac_alert_regs_chk.sv ***
// Purpose: Port-level checks of the alert setup register block
// Assumes: One clock domain, reset asynchronous and active high
// Notes:   Latency windows follow the hand-over timing of the block
`timescale 1ns/10ps
`default_nettype none
module tac_alert_regs_chk (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // Register port
   input wire logic [2:0]  regAddr,
   input wire logic [15:0] regWrData,
   input wire logic        regWrite,
   input wire logic [15:0] regRdData,
   // Converter and limits
   input wire logic [12:0] sampleTemp,
   input wire logic        sampleValid,
   input wire logic        convRun,
   input wire logic [12:0] recordedTemp,
   input wire logic [15:0] lowerLimit,
   input wire logic [15:0] criticalLimit,
   input wire logic        alarmLimitFreeze,
   input wire logic        critLimitFreeze,
   // Alert pin
   input wire logic        alertPinOut,
   input wire logic        alertPinOe
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // Setup writes; a halt request counts only when no lock stands before it
   wire setupWr = regWrite && regAddr == 3'h1;
   wire haltOk  = setupWr && regWrData[8] && !alarmLimitFreeze && !critLimitFreeze;
   sequence alarmLockWr;
      setupWr && regWrData[6];
   endsequence
   sequence critLockWr;
      setupWr && regWrData[7];
   endsequence
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_FEATURE: assert property (!$past(rst) && $past(regAddr) == 3'h0 |-> regRdData == 16'h007f)
      else $error("feature word wrong");
   AST_SETUP_RSVD: assert property (!$past(rst) && $past(regAddr) == 3'h1 |-> (regRdData & 16'hf820) == 16'h0000)
      else $error("setup reserved or clear bit set");
   AST_UPPER_FMT: assert property (!$past(rst) && $past(regAddr) == 3'h2 |-> (regRdData & 16'he003) == 16'h0000)
      else $error("upper limit unused bits set");
   AST_STATE_GATED: assert property ($past(regAddr) == 3'h1 && !regRdData[3] |-> !regRdData[4])
      else $error("state copy set while disabled");
   AST_ALARM_LOCK: assert property (alarmLockWr |-> ##[1:2] alarmLimitFreeze)
      else $error("alarm lock not taken");
   AST_CRIT_LOCK: assert property (critLockWr |-> ##[1:2] critLimitFreeze)
      else $error("critical lock not taken");
   AST_LOCK_HOLD: assert property (!$fell(alarmLimitFreeze) && !$fell(critLimitFreeze))
      else $error("lock dropped without reset");
   AST_HALT_CAUSE: assert property ($fell(convRun) |-> $past(haltOk) || $past(haltOk, 2))
      else $error("halt without an allowed request");
   AST_HALT_FREEZE: assert property (!convRun && !$past(convRun) |-> $stable(recordedTemp))
      else $error("reading moved while halted");
   AST_OPEN_DRAIN: assert property (alertPinOut == 1'b0)
      else $error("alert pin driven high");
endmodule // tac_alert_regs_chk
`default_nettype wire

// *** sim/tac_host_model.sv ***
// Purpose: Host and converter model facing the alert register block
// Assumes: Requests change 1 ns after a rising edge
// Notes:   Lower and critical limits start at 0 and 50 degrees; setLower moves the lower one
`timescale 1ns/10ps
`default_nettype none
module tac_host_model (
   // Clock
   input  wire logic        clk,
   // Register port
   output var  logic [2:0]  regAddr,
   output var  logic [15:0] regWrData,
   output var  logic        regWrite,
   input  wire logic [15:0] regRdData,
   // Converter and outer limits
   output var  logic [12:0] sampleTemp,
   output var  logic        sampleValid,
   output var  logic [15:0] lowerLimit,
   output var  logic [15:0] criticalLimit
);
   // Idle levels at time zero
   initial begin
      regAddr = 3'h0;
      regWrData = 16'h0000;
      regWrite = 1'b0;
      sampleTemp = 13'h0000;
      sampleValid = 1'b0;
      lowerLimit = 16'h0000;
      criticalLimit = 16'h0320;
   end
   // ----------------------------------------------------------------
   // Requests
   // ----------------------------------------------------------------
   // Stale data is inverted so it never passes for a fresh word; an idle edge keeps strobes apart
   task automatic wrReg(input logic [2:0] a, input logic [15:0] d);
      regAddr = a;
      regWrData = d;
      regWrite = 1'b1;
      @(posedge clk);
      #1;
      regWrite = 1'b0;
      regWrData = ~d;
      @(posedge clk);
      #1;
   endtask
   // Read word is registered one edge after the pointer
   task automatic rdReg(input logic [2:0] a, output logic [15:0] d);
      regAddr = a;
      @(posedge clk);
      #1;
      d = regRdData;
   endtask
   task automatic sample(input logic [12:0] t);
      sampleTemp = t;
      sampleValid = 1'b1;
      @(posedge clk);
      #1;
      sampleValid = 1'b0;
      sampleTemp = ~t;
      // Let flags and the event latch settle so a following clear is not overtaken
      repeat (3) @(posedge clk);
      #1;
   endtask
   // Lower limit is held outside the block; changed between edges like any request
   task automatic setLower(input logic [15:0] lo);
      lowerLimit = lo;
      @(posedge clk);
      #1;
   endtask
endmodule // tac_host_model
`default_nettype wire

// *** sim/test_tac_alert_regs.sv ***
// Purpose: Self-checking bench of the alert setup register block
// Assumes: Host model changes inputs 1 ns after the rising edge
// Notes:   Upper limit 25, lower 0, critical 50 degrees
`timescale 1ns/10ps
`default_nettype none
module test_tac_alert_regs;
   logic        clk = 1'b0;
   logic        rst;
   logic [2:0]  regAddr;
   logic [15:0] regWrData, regRdData, lowerLimit, criticalLimit;
   logic [12:0] sampleTemp, recordedTemp;
   logic        regWrite, sampleValid, convRun, alarmLimitFreeze, critLimitFreeze, alertPinOut, alertPinOe;
   logic [12:0] hs [4] = '{13'h000, 13'h018, 13'h030, 13'h060};
   int          errorCnt = 0;
   int          nCompared = 0;
   int          cycles = 0;
   // 25 MHz clock
   always #20 clk = ~clk;
   tac_alert_regs dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
      .regRdData(regRdData), .sampleTemp(sampleTemp), .sampleValid(sampleValid), .convRun(convRun),
      .recordedTemp(recordedTemp), .lowerLimit(lowerLimit), .criticalLimit(criticalLimit),
      .alarmLimitFreeze(alarmLimitFreeze), .critLimitFreeze(critLimitFreeze), .alertPinOut(alertPinOut),
      .alertPinOe(alertPinOe));
   tac_host_model host (.clk(clk), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
      .regRdData(regRdData), .sampleTemp(sampleTemp), .sampleValid(sampleValid), .lowerLimit(lowerLimit),
      .criticalLimit(criticalLimit));
   // Every comparison passes through here
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      nCompared++;
      if (seen !== exp) begin
         errorCnt++;
         $display("unexpected at %0t: seen %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic rdChk(input logic [2:0] a, input logic [15:0] exp);
      logic [15:0] v;
      host.rdReg(a, v);
      chk(v, exp);
   endtask
   // Pin pull-down and setup bit 4; five edges cover the alert pipeline
   task automatic alertChk(input logic oe, input logic st);
      logic [15:0] v;
      repeat (5) @(posedge clk);
      #1;
      host.rdReg(3'h1, v);
      chk({15'h0000, alertPinOe}, {15'h0000, oe});
      chk({15'h0000, v[4]}, {15'h0000, st});
   endtask
   task automatic doReset();
      rst = 1'b1;
      repeat (10) @(posedge clk);
      #1;
      rst = 1'b0;
   endtask
   task automatic giveVerdict();
      $display("compared %0d, mismatches %0d", nCompared, errorCnt);
      if (errorCnt == 0 && nCompared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Hang guard, far above the length of the run
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         errorCnt++;
         giveVerdict();
      end
   end
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic testRegs();
      rdChk(3'h0, 16'h007f);
      host.wrReg(3'h0, 16'hffff);
      rdChk(3'h0, 16'h007f);
      host.wrReg(3'h1, 16'hf800);
      rdChk(3'h1, 16'h0000);
      host.wrReg(3'h2, 16'hffff);
      rdChk(3'h2, 16'h1ffc);
      rdChk(3'h5, 16'h0000);
      host.wrReg(3'h2, 16'h0190);
      $display("registers test done");
   endtask
   task automatic testCompare();
      host.wrReg(3'h1, 16'h0008);
      host.sample(13'h1a0);
      alertChk(1'b1, 1'b1);
      host.wrReg(3'h1, 16'h000a);
      alertChk(1'b0, 1'b1);
      host.wrReg(3'h1, 16'h0002);
      alertChk(1'b1, 1'b0);
      host.wrReg(3'h1, 16'h0020);
      alertChk(1'b0, 1'b0);
      // Each margin code: one step above limit minus margin holds, the boundary releases
      for (int i = 0; i < 4; i++) begin
         host.wrReg(3'h1, {5'h00, i[1:0], 9'h028});
         host.sample(13'h1a0);
         host.sample(13'h191 - hs[i]);
         alertChk(1'b1, 1'b1);
         host.sample(13'h190 - hs[i]);
         alertChk(1'b0, 1'b0);
      end
      rdChk(3'h1, 16'h0608);
      host.wrReg(3'h1, 16'h0008);
      host.sample(13'h1a0);
      host.wrReg(3'h2, 16'h01e0);
      alertChk(1'b0, 1'b0);
      host.setLower(16'h00a0);
      host.sample(13'h050);
      alertChk(1'b1, 1'b1);
      host.setLower(16'h0000);
      alertChk(1'b0, 1'b0);
      host.wrReg(3'h2, 16'h0190);
      $display("comparator test done");
   endtask
   task automatic testInterrupt();
      host.wrReg(3'h1, 16'h0009);
      host.sample(13'h0a0);
      host.wrReg(3'h1, 16'h0029);
      alertChk(1'b0, 1'b0);
      host.sample(13'h1a0);
      alertChk(1'b1, 1'b1);
      host.sample(13'h0a0);
      alertChk(1'b1, 1'b1);
      host.wrReg(3'h1, 16'h0029);
      alertChk(1'b0, 1'b0);
      host.sample(13'h340);
      host.wrReg(3'h1, 16'h0029);
      alertChk(1'b1, 1'b1);
      host.sample(13'h1e0);
      alertChk(1'b0, 1'b0);
      host.wrReg(3'h1, 16'h000c);
      alertChk(1'b0, 1'b0);
      host.sample(13'h340);
      alertChk(1'b1, 1'b1);
      $display("interrupt test done");
   endtask
   task automatic testHalt();
      host.wrReg(3'h1, 16'h0008);
      host.sample(13'h1a0);
      host.wrReg(3'h1, 16'h0108);
      host.sample(13'h0a0);
      chk({15'h0000, convRun}, 16'h0000);
      chk({3'h0, recordedTemp}, 16'h01a0);
      alertChk(1'b1, 1'b1);
      host.wrReg(3'h1, 16'h0109);
      host.wrReg(3'h1, 16'h0129);
      alertChk(1'b0, 1'b0);
      host.sample(13'h0a0);
      alertChk(1'b0, 1'b0);
      host.wrReg(3'h1, 16'h0008);
      chk({15'h0000, convRun}, 16'h0001);
      $display("halt test done");
   endtask
   task automatic testLocks();
      host.wrReg(3'h1, 16'h0100);
      host.wrReg(3'h1, 16'h0140);
      chk({15'h0000, alarmLimitFreeze}, 16'h0001);
      host.wrReg(3'h1, 16'h0040);
      rdChk(3'h1, 16'h0040);
      host.wrReg(3'h1, 16'h077f);
      rdChk(3'h1, 16'h0040);
      host.wrReg(3'h1, 16'h0000);
      rdChk(3'h1, 16'h0040);
      host.wrReg(3'h2, 16'h0200);
      rdChk(3'h2, 16'h0190);
      doReset();
      rdChk(3'h1, 16'h0000);
      host.wrReg(3'h1, 16'h0080);
      chk({15'h0000, critLimitFreeze}, 16'h0001);
      host.wrReg(3'h1, 16'h0184);
      rdChk(3'h1, 16'h0084);
      host.wrReg(3'h2, 16'h0200);
      rdChk(3'h2, 16'h0200);
      $display("lock test done");
   endtask
   // Main sequence
   initial begin
      doReset();
      testRegs();
      testCompare();
      testInterrupt();
      testHalt();
      testLocks();
      giveVerdict();
   end
endmodule // test_tac_alert_regs
bind tac_alert_regs tac_alert_regs_chk chk_i (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
   .regWrite(regWrite), .regRdData(regRdData), .sampleTemp(sampleTemp), .sampleValid(sampleValid),
   .convRun(convRun), .recordedTemp(recordedTemp), .lowerLimit(lowerLimit), .criticalLimit(criticalLimit),
   .alarmLimitFreeze(alarmLimitFreeze), .critLimitFreeze(critLimitFreeze), .alertPinOut(alertPinOut),
   .alertPinOe(alertPinOe));
`default_nettype wire
